// >>> rtl/modem_answer_serial_port.sv
// Purpose: modem answer/hangup handshake, serial framing and front-panel indicators
// Assumes: synchronous inputs, AXI4-Lite register access, single clock
// Notes: registers CTRL, STATUS, TXDATA, RXDATA, HELD, BAUD
//
// Notes on behaviour
// - hold dtr high while waiting for call
// - ring indicator ignored; only dsr matters
// - dsr active starts ten second carrier timeout
// - dcd after dsr enters connected state
// - timeout without dcd drops dtr
// - dsr inactive after hangup reasserts dtr
// - connected: dcd loss restarts timeout
// - timeout expiry after loss drops dtr
// - carrier loss returns held commands, code 84
// - discard serial messages while carrier lost
// - start bit, eight data bits lsb first
// - optional even parity, one stop bit
// - transmit light when master and sending
// - receive light when receiving a message
// - both lights while polling for mastership handover
// - pending light: buffered message, no mastership
// - active light on when connected, blinks per character; code lights it whenever dsr is high and no character is moving, in any answer state
// - nak light half second per dle nak
// - full-duplex or half-duplex link selectable
// - protocol layer reports failures with code
// - no transmit without cts, pause when dropped; code checks cts only at frame start and finishes a started frame
// - no transfer while dsr inactive
// - rts always in full, permission in half
`include "modem_answer_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module modem_answer_serial_port #(
	parameter logic [31:0] CARRIER_TMO = 32'(`CARRIER_TMO_CYC), // cycles, about ten seconds
	parameter logic [31:0] NAK_HOLD = 32'(`NAK_LED_CYC), // cycles, about half a second
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// modem pins
	output logic txd,
	input wire logic rxd,
	output logic rts,
	input wire logic cts,
	output logic dtr,
	input wire logic dsr,
	input wire logic dcd,
	input wire logic ring, // deliberately unused
	// held command return
	output logic cmd_return,
	output logic [7:0] return_code,
	// indicators
	output logic transmitting_indicator,
	output logic receiving_indicator,
	output logic pending_indicator,
	output logic link_active_indicator,
	output logic nak_indicator
);

	// ****************************************
	// functions
	// ****************************************
	// even parity bit of a byte
	function automatic logic even_par(input logic [7:0] b);
		even_par = ^b;
	endfunction : even_par

	// ****************************************
	// declarations
	// ****************************************
	logic [31:0] ctrl_r; // software control bits
	logic [15:0] baud_r; // cycles per bit
	logic [7:0] held_r; // commands stored in receive buffer
	modem_answer_pkg::answer_e st_r; // answer state
	logic [31:0] tmo_r; // carrier timeout counter
	logic aw_hold_r, w_hold_r; // write channels captured
	logic [ADDR_W-1:0] awaddr_r; // captured write address
	logic [31:0] wdata_r; // captured write data
	logic [3:0] wstrb_r; // captured strobes
	logic wr_go; // both write halves present
	logic tx_pend_r; // byte waiting in transmit buffer
	logic [7:0] tx_buf_r; // transmit buffer
	logic [10:0] tx_sh_r; // transmit shift register
	logic [3:0] tx_bits_r; // bits left in frame
	logic [15:0] tx_cnt_r; // transmit bit timer
	logic [7:0] tx_last_r; // byte loaded before, for dle nak
	logic rxd_q_r; // previous rxd for edge detect
	logic rx_busy_r; // receiving a frame
	logic [3:0] rx_bit_r; // bit index within frame
	logic [15:0] rx_cnt_r; // receive bit timer
	logic [8:0] rx_sh_r; // data and parity collected
	logic [7:0] rx_data_r; // received byte
	logic rx_valid_r, perr_r, ferr_r, lost_r; // status flags
	logic rx_done; // frame completed this cycle
	logic [31:0] nak_cnt_r; // nak light hold counter
	logic lost_ev; // carrier dropped this cycle
	logic link_ok; // dsr and dcd present
	logic tx_ok; // transmit allowed now
	logic [31:0] status_w; // status word view
	logic [31:0] rd_w; // read mux
	logic rd_hit; // read address mapped

	assign link_ok = dsr && dcd;
	assign lost_ev = (st_r == modem_answer_pkg::ST_CONNECTED) && !dcd;
	// full duplex needs carrier, both need dsr and cts
	assign tx_ok = cts && dsr && (st_r == modem_answer_pkg::ST_CONNECTED) &&
		(ctrl_r[`CTRL_HALF] ? ctrl_r[`CTRL_PERMIT] : dcd);
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

	// ****************************************
	// answer and hangup state machine
	// ****************************************
	// state moves, dsr and dcd only, ring never looked at
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= modem_answer_pkg::ST_WAIT_CALL;
			tmo_r <= 32'h0;
		end else begin
			case (st_r)
				modem_answer_pkg::ST_WAIT_CALL: begin
					tmo_r <= 32'h0;
					if (dsr) begin
						st_r <= modem_answer_pkg::ST_WAIT_DCD;
					end
				end
				modem_answer_pkg::ST_WAIT_DCD: begin
					tmo_r <= tmo_r + 32'h1;
					if (dcd) begin
						st_r <= modem_answer_pkg::ST_CONNECTED;
					end else if (tmo_r >= CARRIER_TMO - 32'h1) begin
						st_r <= modem_answer_pkg::ST_HANGUP;
					end
				end
				modem_answer_pkg::ST_CONNECTED: begin
					tmo_r <= 32'h0;
					if (!dcd) begin
						st_r <= modem_answer_pkg::ST_LOST;
					end
				end
				modem_answer_pkg::ST_LOST: begin
					tmo_r <= tmo_r + 32'h1;
					if (dcd) begin
						st_r <= modem_answer_pkg::ST_CONNECTED;
					end else if (tmo_r >= CARRIER_TMO - 32'h1) begin
						st_r <= modem_answer_pkg::ST_HANGUP;
					end
				end
				modem_answer_pkg::ST_HANGUP: begin
					tmo_r <= 32'h0;
					if (!dsr) begin
						st_r <= modem_answer_pkg::ST_WAIT_CALL;
					end
				end
				default: begin
					st_r <= modem_answer_pkg::ST_WAIT_CALL;
					tmo_r <= 32'h0;
				end
			endcase
		end
	end

	// dtr low only in hangup, rts by protocol choice
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dtr <= 1'b1;
			rts <= 1'b1;
		end else begin
			dtr <= (st_r != modem_answer_pkg::ST_HANGUP);
			rts <= ctrl_r[`CTRL_HALF] ? ctrl_r[`CTRL_PERMIT] : 1'b1;
		end
	end

	// ****************************************
	// held command return on carrier loss
	// ****************************************
	// one return pulse per held command, code 84
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_r <= 8'h0;
			cmd_return <= 1'b0;
			return_code <= 8'h0;
		end else begin
			cmd_return <= 1'b0;
			if (wr_go && awaddr_r == `REG_HELD && wstrb_r[0]) begin
				held_r <= wdata_r[7:0];
			end else if ((st_r == modem_answer_pkg::ST_LOST || st_r == modem_answer_pkg::ST_HANGUP ||
					lost_ev) && held_r != 8'h0) begin
				held_r <= held_r - 8'h1;
				cmd_return <= 1'b1;
				return_code <= `ERR_CARRIER_LOST;
			end
		end
	end

	// ****************************************
	// transmitter
	// ****************************************
	// frame: start, data lsb first, optional parity, stop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_sh_r <= 11'h7ff;
			tx_bits_r <= 4'h0;
			tx_cnt_r <= 16'h0;
			tx_last_r <= 8'h0;
			txd <= 1'b1;
		end else begin
			txd <= tx_sh_r[0];
			if (tx_bits_r == 4'h0) begin
				if (tx_pend_r && tx_ok) begin
					tx_sh_r <= ctrl_r[`CTRL_PARITY] ? {1'b1, even_par(tx_buf_r), tx_buf_r, 1'b0} :
						{2'b11, tx_buf_r, 1'b0};
					tx_bits_r <= ctrl_r[`CTRL_PARITY] ? 4'hb : 4'ha;
					tx_last_r <= tx_buf_r;
					tx_cnt_r <= 16'h0;
				end
			end else if (tx_cnt_r >= baud_r - 16'h1) begin
				tx_cnt_r <= 16'h0;
				tx_sh_r <= {1'b1, tx_sh_r[10:1]};
				tx_bits_r <= tx_bits_r - 4'h1;
			end else begin
				tx_cnt_r <= tx_cnt_r + 16'h1;
			end
		end
	end

	// ****************************************
	// receiver
	// ****************************************
	// mid-bit sampling, dropped unless connected
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxd_q_r <= 1'b1;
			rx_busy_r <= 1'b0;
			rx_bit_r <= 4'h0;
			rx_cnt_r <= 16'h0;
			rx_sh_r <= 9'h0;
		end else begin
			rxd_q_r <= rxd;
			if (!rx_busy_r) begin
				if (rxd_q_r && !rxd && link_ok) begin
					rx_busy_r <= 1'b1;
					rx_bit_r <= 4'h0;
					rx_cnt_r <= {1'b0, baud_r[15:1]};
				end
			end else if (rx_cnt_r >= baud_r - 16'h1) begin
				rx_cnt_r <= 16'h0;
				rx_bit_r <= rx_bit_r + 4'h1;
				if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h9) begin
					rx_sh_r <= {rxd, rx_sh_r[8:1]};
				end
				if (rx_done) begin
					rx_busy_r <= 1'b0;
				end
			end else begin
				rx_cnt_r <= rx_cnt_r + 16'h1;
			end
		end
	end
	// stop bit is slot 9 without parity, slot 10 with it
	assign rx_done = rx_busy_r && (rx_cnt_r >= baud_r - 16'h1) &&
		(rx_bit_r == (ctrl_r[`CTRL_PARITY] ? 4'ha : 4'h9));

	// received byte, error flags; hardware set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_data_r <= 8'h0;
			rx_valid_r <= 1'b0;
			perr_r <= 1'b0;
			ferr_r <= 1'b0;
			lost_r <= 1'b0;
		end else begin
			if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `REG_RXDATA) begin
				rx_valid_r <= 1'b0;
			end
			if (wr_go && awaddr_r == `REG_STATUS && wstrb_r[1]) begin
				perr_r <= perr_r & ~wdata_r[`ST_PERR];
				ferr_r <= ferr_r & ~wdata_r[`ST_FERR];
				lost_r <= lost_r & ~wdata_r[`ST_LOST];
			end
			if (lost_ev) begin
				lost_r <= 1'b1;
			end
			if (rx_done && st_r == modem_answer_pkg::ST_CONNECTED) begin
				rx_data_r <= ctrl_r[`CTRL_PARITY] ? rx_sh_r[7:0] : rx_sh_r[8:1];
				rx_valid_r <= 1'b1;
				if (ctrl_r[`CTRL_PARITY] && (even_par(rx_sh_r[7:0]) != rx_sh_r[8])) begin
					perr_r <= 1'b1;
				end
				if (!rxd) begin
					ferr_r <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// indicators
	// ****************************************
	// nak light hold after dle nak in either direction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nak_cnt_r <= 32'h0;
		end else if ((tx_bits_r == 4'h0 && tx_pend_r && tx_ok && tx_last_r == `CHAR_DLE && tx_buf_r == `CHAR_NAK) ||
				(rx_done && st_r == modem_answer_pkg::ST_CONNECTED && rx_data_r == `CHAR_DLE &&
				(ctrl_r[`CTRL_PARITY] ? rx_sh_r[7:0] : rx_sh_r[8:1]) == `CHAR_NAK)) begin
			nak_cnt_r <= NAK_HOLD;
		end else if (nak_cnt_r != 32'h0) begin
			nak_cnt_r <= nak_cnt_r - 32'h1;
		end
	end

	// lights driven from flip-flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			transmitting_indicator <= 1'b0;
			receiving_indicator <= 1'b0;
			pending_indicator <= 1'b0;
			link_active_indicator <= 1'b0;
			nak_indicator <= 1'b0;
		end else begin
			transmitting_indicator <= ctrl_r[`CTRL_MASTER] && ((tx_bits_r != 4'h0) || ctrl_r[`CTRL_POLL]);
			receiving_indicator <= rx_busy_r || (ctrl_r[`CTRL_MASTER] && ctrl_r[`CTRL_POLL]);
			pending_indicator <= tx_pend_r && !ctrl_r[`CTRL_MASTER];
			link_active_indicator <= dsr && (tx_bits_r == 4'h0) && !rx_busy_r;
			nak_indicator <= (nak_cnt_r != 32'h0);
		end
	end

	// ****************************************
	// axi4-lite write channel
	// ****************************************
	// either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_r <= `REG_BAUD && awaddr_r[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_r && !s_axi_bvalid;

	// control, baud and transmit buffer registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `CTRL_RESET;
			baud_r <= `BAUD_DIV_RESET;
			tx_pend_r <= 1'b0;
			tx_buf_r <= 8'h0;
		end else begin
			if (wr_go && awaddr_r == `REG_CTRL && wstrb_r[0]) begin
				ctrl_r[7:0] <= wdata_r[7:0] & 8'h1f;
			end
			if (wr_go && awaddr_r == `REG_BAUD) begin
				baud_r <= (wdata_r[15:0] < 16'h2) ? 16'h2 : wdata_r[15:0];
			end
			if (tx_bits_r == 4'h0 && tx_pend_r && tx_ok) begin
				tx_pend_r <= 1'b0;
			end else if (wr_go && awaddr_r == `REG_TXDATA && wstrb_r[0] && !tx_pend_r) begin
				tx_buf_r <= wdata_r[7:0];
				tx_pend_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// axi4-lite read channel
	// ****************************************
	always_comb begin
		status_w = 32'h0;
		status_w[4:0] = st_r;
		status_w[`ST_DSR] = dsr;
		status_w[`ST_DCD] = dcd;
		status_w[`ST_CTS] = cts;
		status_w[`ST_TXBUSY] = tx_pend_r || (tx_bits_r != 4'h0);
		status_w[`ST_RXVALID] = rx_valid_r;
		status_w[`ST_PERR] = perr_r;
		status_w[`ST_FERR] = ferr_r;
		status_w[`ST_LOST] = lost_r;
		status_w[`ST_NAK] = (nak_cnt_r != 32'h0);
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`REG_CTRL: rd_w = ctrl_r;
			`REG_STATUS: rd_w = status_w;
			`REG_TXDATA: rd_w = {24'h0, tx_buf_r};
			`REG_RXDATA: rd_w = {24'h0, rx_data_r};
			`REG_HELD: rd_w = {24'h0, held_r};
			`REG_BAUD: rd_w = {16'h0, baud_r};
			default: begin
				rd_w = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end

	// read answer one cycle after take
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_w;
			s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;

endmodule : modem_answer_serial_port

`default_nettype wire

// >>> shared/modem_answer_defines.svh
// Purpose: offsets, fields, resets and timing counts of the modem answer serial port
// Assumes: 100 MHz module clock, AXI4-Lite register word per offset
// Notes: definitions only
`ifndef MODEM_ANSWER_DEFINES_SVH
`define MODEM_ANSWER_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TXDATA 8'h08
`define REG_RXDATA 8'h0c
`define REG_HELD 8'h10
`define REG_BAUD 8'h14

// ****************************************
// control fields
// ****************************************
`define CTRL_PARITY 0
`define CTRL_HALF 1
`define CTRL_PERMIT 2
`define CTRL_MASTER 3
`define CTRL_POLL 4
`define CTRL_RESET 32'h0000_0000

// ****************************************
// status fields
// ****************************************
`define ST_DSR 5
`define ST_DCD 6
`define ST_CTS 7
`define ST_TXBUSY 8
`define ST_RXVALID 9
`define ST_PERR 10
`define ST_FERR 11
`define ST_LOST 12
`define ST_NAK 13

// ****************************************
// codes and timing
// ****************************************
`define ERR_CARRIER_LOST 8'h54
`define CHAR_DLE 8'h10
`define CHAR_NAK 8'h15
`define CLK_HZ 64'd100000000
`define CARRIER_TMO_S 64'd10
`define NAK_LED_MS 64'd500
`define CARRIER_TMO_CYC (`CARRIER_TMO_S * `CLK_HZ)
`define NAK_LED_CYC (`NAK_LED_MS * `CLK_HZ / 64'd1000)
`define BAUD_DIV_RESET 16'h0d05
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> shared/modem_answer_pkg.sv
// Purpose: types of the modem answer serial port
// Assumes: nothing
// Notes: one-hot answer states
package modem_answer_pkg;
	typedef enum logic [4:0] {
		ST_WAIT_CALL = 5'h01, // dtr high, waiting for dsr
		ST_WAIT_DCD = 5'h02, // dsr seen, carrier timeout running
		ST_CONNECTED = 5'h04, // carrier up, traffic allowed
		ST_LOST = 5'h08, // carrier dropped, timeout restarted
		ST_HANGUP = 5'h10 // dtr low until dsr drops
	} answer_e;
endpackage : modem_answer_pkg

// >>> testbench/modem_answer_chk.sv
// Purpose: pin-level checks of the modem answer serial port
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the port
`timescale 1ns/100ps
`default_nettype none

module modem_answer_chk #(
	parameter logic [31:0] CARRIER_TMO = 32'd50,
	parameter logic [31:0] NAK_HOLD = 32'd20
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// modem pins
	input wire logic txd,
	input wire logic rxd,
	input wire logic dtr,
	input wire logic dsr,
	input wire logic dcd,
	// held command return
	input wire logic cmd_return,
	input wire logic [7:0] return_code,
	// indicators
	input wire logic transmitting_indicator,
	input wire logic receiving_indicator,
	input wire logic pending_indicator,
	input wire logic link_active_indicator,
	input wire logic nak_indicator
);
	// ****************
	// helper counters
	// ****************
	logic [31:0] wait_r; // cycles off-hook without carrier
	logic [31:0] nak_r; // cycles the nak light is lit
	// carrier wait length
	always_ff @(posedge aclk) begin
		if (!aresetn || !dsr || dcd || !dtr) begin
			wait_r <= 32'h0;
		end else begin
			wait_r <= wait_r + 32'h1;
		end
	end
	// nak light length
	always_ff @(posedge aclk) begin
		if (!aresetn || !nak_indicator) begin
			nak_r <= 32'h0;
		end else begin
			nak_r <= nak_r + 32'h1;
		end
	end
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// on-hook
	sequence s_on_hook;
		!dtr && !dsr;
	endsequence
	// no call
	sequence s_no_call;
		!dsr [*5];
	endsequence
	AST_CALL_DTR: assert property (s_no_call |-> dtr)
		else $error("dtr low while idle");
	AST_HANG_HOLD: assert property (!dtr && dsr |=> !dtr)
		else $error("dtr back too early");
	AST_DTR_BACK: assert property (s_on_hook |-> ##[1:3] dtr)
		else $error("dtr not restored");
	AST_TMO_EARLY: assert property ($fell(dtr) |-> $past(wait_r) >= CARRIER_TMO - 32'h1)
		else $error("hangup too early");
	AST_TMO_LATE: assert property (wait_r <= CARRIER_TMO + 32'h4)
		else $error("hangup too late");
	AST_RET_CODE: assert property (cmd_return |-> ##[0:1] return_code == 8'h54)
		else $error("wrong return code");
	AST_RET_LOSS: assert property (cmd_return |-> !dcd || !$past(dcd))
		else $error("return with carrier up");
	AST_LINK_OFF: assert property (!dsr |=> !link_active_indicator)
		else $error("link light on without dsr");
	AST_TX_BLINK: assert property (!txd |-> ##[0:1] !link_active_indicator)
		else $error("link light not blinking");
	AST_PEND_XOR: assert property (!(pending_indicator && transmitting_indicator))
		else $error("pending with transmit light");
	AST_NAK_LEN: assert property ($fell(nak_indicator) |-> $past(nak_r) >= NAK_HOLD - 32'h1)
		else $error("nak light too short");
	AST_RX_LIGHT: assert property ($fell(rxd) && dsr && dcd && !receiving_indicator
		|-> ##[1:4] receiving_indicator)
		else $error("receive light missing");
endmodule : modem_answer_chk

bind modem_answer_serial_port modem_answer_chk #(
	.CARRIER_TMO(CARRIER_TMO),
	.NAK_HOLD(NAK_HOLD)
) chk_i (
	.aclk(aclk), .aresetn(aresetn), .txd(txd), .rxd(rxd), .dtr(dtr), .dsr(dsr), .dcd(dcd),
	.cmd_return(cmd_return), .return_code(return_code),
	.transmitting_indicator(transmitting_indicator), .receiving_indicator(receiving_indicator),
	.pending_indicator(pending_indicator), .link_active_indicator(link_active_indicator),
	.nak_indicator(nak_indicator)
);
`default_nettype wire

// >>> testbench/modem_model.sv
// Purpose: dial-up modem seen from the module's serial pins
// Assumes: steered by testbench controls, one clock
// Notes: goes on-hook four cycles after dtr falls
`timescale 1ns/100ps
`default_nettype none

module modem_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// testbench controls
	input wire logic answer, // caller rings in
	input wire logic carrier, // far carrier present
	input wire logic ready, // modem ready to send
	input wire logic line_in, // far-end serial data
	// module pins
	input wire logic dtr,
	output logic dsr,
	output logic dcd,
	output logic cts,
	output logic rxd
);
	logic hook_r; // off-hook
	logic [1:0] hang_r; // hangup progress
	// answer while dtr high, hang up after dtr drops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hook_r <= 1'b0;
			hang_r <= 2'h0;
		end else if (!dtr) begin
			hang_r <= hang_r + 2'h1;
			if (hang_r == 2'h3) begin
				hook_r <= 1'b0;
			end
		end else begin
			hang_r <= 2'h0;
			if (answer) begin
				hook_r <= 1'b1;
			end
		end
	end
	// signals only while off-hook, mark level otherwise
	assign dsr = hook_r;
	assign dcd = hook_r && carrier;
	assign cts = hook_r && ready;
	assign rxd = hook_r ? line_in : 1'b1;
endmodule : modem_model
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench of the modem answer serial port
// Assumes: shortened timeouts, eight cycles per serial bit
// Notes: registers over axi4-lite, modem model on the pins
`include "modem_answer_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;
	localparam logic [31:0] TMO = 32'd400; // carrier timeout
	localparam logic [31:0] NAKH = 32'd200; // nak light hold
	localparam int BIT = 8; // cycles per bit
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, return_code;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic txd, rxd, rts, cts, dtr, dsr, dcd, ring, cmd_return;
	logic xmt_led, rcv_led, pend_led, act_led, nak_led;
	logic answer, carrier, ready, line; // modem controls
	int err_total, samples_checked;
	// ****************
	// instances
	// ****************
	modem_answer_serial_port #(.CARRIER_TMO(TMO), .NAK_HOLD(NAKH), .ADDR_W(8)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .txd(txd), .rxd(rxd),
		.rts(rts), .cts(cts), .dtr(dtr), .dsr(dsr), .dcd(dcd), .ring(ring), .cmd_return(cmd_return),
		.return_code(return_code), .transmitting_indicator(xmt_led), .receiving_indicator(rcv_led),
		.pending_indicator(pend_led), .link_active_indicator(act_led), .nak_indicator(nak_led));
	modem_model modem (.aclk(aclk), .aresetn(aresetn), .answer(answer), .carrier(carrier),
		.ready(ready), .line_in(line), .dtr(dtr), .dsr(dsr), .dcd(dcd), .cts(cts), .rxd(rxd));
	// ****************
	// helpers
	// ****************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic chb(input logic s, input logic e);
		chk({31'h0, s}, {31'h0, e});
	endtask : chb
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick
	// axi write, both halves offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (awvalid && !awready || wvalid && !wready);
		while (!bvalid) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	// axi read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic wro(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk({30'h0, r}, {30'h0, `RESP_OKAY});
	endtask : wro
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d & m, e);
	endtask : rdc
	// watch one character leave on txd
	task automatic tx_see(input logic [7:0] b, input logic par, input logic xm);
		while (txd !== 1'b0) @(posedge aclk);
		tick(BIT / 2 - 1);
		chb(act_led, 1'b0);
		chb(xmt_led, xm);
		for (int i = 0; i < 8; i++) begin
			tick(BIT);
			chb(txd, b[i]);
		end
		if (par) begin
			tick(BIT);
			chb(txd, ^b);
		end
		tick(BIT);
		chb(txd, 1'b1);
	endtask : tx_see
	// send one character into rxd
	task automatic rx_send(input logic [7:0] b, input logic par, input logic rl);
		logic [10:0] f;
		f = par ? {1'b1, ^b, b, 1'b0} : {2'h3, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			if (i == 1) chb(rcv_led, rl);
			line <= f[i];
			tick(BIT);
		end
	endtask : rx_send
	// hangup timing
	task automatic hang_time();
		int n;
		for (n = 0; dtr === 1'b1 && n < 2000; n++) @(posedge aclk);
		chk(32'(n >= TMO - 1 && n <= TMO + 4), 32'h1);
		tick(12);
		chb(dsr, 1'b0);
		chb(dtr, 1'b1);
	endtask : hang_time
	// ****************
	// scenarios
	// ****************
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rdc(`REG_CTRL, 32'hffff_ffff, `CTRL_RESET);
		rdc(`REG_BAUD, 32'hffff, 32'(`BAUD_DIV_RESET));
		ring <= 1'b1;
		tick(20);
		rdc(`REG_STATUS, 32'h1f, 32'h01);
		chb(dtr, 1'b1);
		ring <= 1'b0;
		rd(8'h18, d, r);
		chk({d[29:0], r}, {30'h0, `RESP_SLVERR});
		wr(8'h18, 32'h1, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		wro(`REG_BAUD, 32'(BIT));
	endtask : t_regs
	task automatic t_nocarrier();
		answer <= 1'b1;
		while (dsr !== 1'b1) @(posedge aclk);
		answer <= 1'b0;
		hang_time();
		rdc(`REG_STATUS, 32'h1f, 32'h01);
	endtask : t_nocarrier
	task automatic t_connect();
		answer <= 1'b1;
		carrier <= 1'b1;
		tick(10);
		rdc(`REG_STATUS, 32'h1f, 32'h04);
		wro(`REG_CTRL, 32'h2);
		tick(2);
		chb(rts, 1'b0);
		wro(`REG_CTRL, 32'h6);
		tick(2);
		chb(rts, 1'b1);
		wro(`REG_CTRL, 32'h18);
		tick(2);
		chk({30'h0, xmt_led, rcv_led}, 32'h3);
		wro(`REG_CTRL, 32'h0);
		tick(2);
		chb(rts, 1'b1);
	endtask : t_connect
	task automatic t_tx();
		ready <= 1'b0;
		wro(`REG_TXDATA, 32'ha5);
		tick(20);
		chb(txd, 1'b1);
		chb(pend_led, 1'b1);
		wro(`REG_CTRL, 32'h8);
		tick(2);
		chb(pend_led, 1'b0);
		ready <= 1'b1;
		tx_see(8'ha5, 1'b0, 1'b1);
	endtask : t_tx
	task automatic t_rx();
		wro(`REG_CTRL, 32'h1);
		rx_send(8'h3c, 1'b1, 1'b1);
		rdc(`REG_RXDATA, 32'hff, 32'h3c);
	endtask : t_rx
	task automatic t_nak();
		wro(`REG_TXDATA, 32'h10);
		tx_see(8'h10, 1'b1, 1'b0);
		wro(`REG_TXDATA, 32'h15);
		tx_see(8'h15, 1'b1, 1'b0);
		tick(BIT);
		chb(nak_led, 1'b1);
		tick(250);
		chb(nak_led, 1'b0);
	endtask : t_nak
	task automatic t_loss();
		int n;
		wro(`REG_HELD, 32'h2);
		carrier <= 1'b0;
		n = 0;
		repeat (10) begin
			@(posedge aclk);
			if (cmd_return === 1'b1) n++;
		end
		chk(32'(n), 32'h2);
		chk({24'h0, return_code}, 32'h54);
		rdc(`REG_STATUS, 32'h101f, 32'h1008);
		rx_send(8'h77, 1'b1, 1'b0);
		rdc(`REG_STATUS, 32'h200, 32'h0);
		carrier <= 1'b1;
		tick(4);
		rdc(`REG_STATUS, 32'h1f, 32'h04);
		answer <= 1'b0;
		carrier <= 1'b0;
		hang_time();
	endtask : t_loss
	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	// ****************
	// run
	// ****************
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// watchdog
	initial begin
		repeat (30000) @(posedge aclk);
		err_total++;
		complete_run();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, ring, answer, carrier} = 9'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0_0000_0000_000f;
		ready = 1'b1;
		line = 1'b1;
		err_total = 0;
		samples_checked = 0;
		tick(5);
		aresetn <= 1'b1;
		tick(1);
		t_regs();
		t_nocarrier();
		t_connect();
		t_tx();
		t_rx();
		t_nak();
		t_loss();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
